/* rtl/wdg_timer.sv */
// Oscillator-driven watchdog timer with AXI4-Lite registers
//
// Behaviour
// - Reset leaves counting and chip reset disabled
// - Control bit 0 enables countdown, else hold
// - Control bit 1 lets expiry reset chip
// - 16-bit prescaler counts every oscillator edge, readable
// - Prescaler at wrap clears, counter decrements
// - Writable wrap divides oscillator edges by value+1
// - 12-bit counter resets to FFF, counts ticks
// - Status bit 0 reads one after trigger
// - Triggered flag cleared only by power-on
// - Prescaler driven by oscillator input only
// - Count-only mode: countdown without chip reset
`timescale 1ns/1ps
module wdg_timer (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          por,
    input  wire logic                          oscillator_input,
    input  wire logic [wdg_pkg::ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [wdg_pkg::DATA_W-1:0]    s_axi_wdata,
    input  wire logic [wdg_pkg::STRB_W-1:0]    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [wdg_pkg::ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [wdg_pkg::DATA_W-1:0]         s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    output logic                               chip_reset,
    output logic                               irq
);
    logic                          rst_any;
    wdg_pkg::wdg_wr_s              wr;
    logic                          wr_valid;
    logic                          wr_ok;
    logic [wdg_pkg::IDX_W-1:0]     rd_idx;
    wdg_pkg::wdg_rd_s              rd;

    logic                          osc_prev;
    logic                          osc_edge;
    logic [wdg_pkg::PRE_W-1:0]     presc;
    logic [wdg_pkg::PRE_W-1:0]     wrap;
    logic                          tick;

    logic [wdg_pkg::CTRL_W-1:0]    ctrl;
    logic                          count_en;
    logic                          trig_en;
    logic [wdg_pkg::CNT_W-1:0]     count;
    logic                          dec;
    logic                          fire;
    logic                          triggered;
    wdg_pkg::wdg_phase_e           phase;

    logic                          hit_ctrl;
    logic                          hit_wrap;
    logic                          cnt_wr;
    logic                          hit_stat;
    logic                          hit_mask;
    logic [wdg_pkg::DATA_W-1:0]    ctrl_m;
    logic [wdg_pkg::DATA_W-1:0]    wrap_m;
    logic [wdg_pkg::DATA_W-1:0]    cnt_m;
    logic [wdg_pkg::DATA_W-1:0]    mask_m;
    logic [wdg_pkg::DATA_W-1:0]    wdat;
    logic [wdg_pkg::CNT_W-1:0]     cnt_wval;

    logic [wdg_pkg::IRQ_W-1:0]     irq_stat;
    logic [wdg_pkg::IRQ_W-1:0]     irq_mask;
    logic [wdg_pkg::IRQ_W-1:0]     irq_evt;
    logic [wdg_pkg::IRQ_W-1:0]     stat_clr;

    function automatic logic [wdg_pkg::DATA_W-1:0] merge(
        input logic [wdg_pkg::DATA_W-1:0] old,
        input wdg_pkg::wdg_wr_s           w
    );
        return (old & ~w.mask) | (w.data & w.mask);
    endfunction

    // Power-on reset implies a full reset of everything else
    assign rst_any = rst || por;

    wdg_axil_slave wdg_axil_slave_inst (
        .clk           (clk),
        .rst           (rst_any),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr            (wr),
        .wr_valid      (wr_valid),
        .wr_ok         (wr_ok),
        .rd_idx        (rd_idx),
        .rd            (rd)
    );

    // Register write decode
    assign hit_ctrl = wr_valid && (wr.idx == wdg_pkg::IDX_CTRL);
    assign hit_wrap = wr_valid && (wr.idx == wdg_pkg::IDX_WRAP);
    assign cnt_wr   = wr_valid && (wr.idx == wdg_pkg::IDX_COUNT);
    assign hit_stat = wr_valid && (wr.idx == wdg_pkg::IDX_IRQ_STAT);
    assign hit_mask = wr_valid && (wr.idx == wdg_pkg::IDX_IRQ_MASK);
    // Read-only registers accept writes silently; holes answer SLVERR
    assign wr_ok = (wr.idx >= wdg_pkg::IDX_CTRL)
                && (wr.idx <= wdg_pkg::IDX_IRQ_MASK);

    assign ctrl_m   = merge(wdg_pkg::DATA_W'(ctrl), wr);
    assign wrap_m   = merge(wdg_pkg::DATA_W'(wrap), wr);
    assign cnt_m    = merge(wdg_pkg::DATA_W'(count), wr);
    assign mask_m   = merge(wdg_pkg::DATA_W'(irq_mask), wr);
    assign wdat     = wr.data & wr.mask;
    assign cnt_wval = cnt_m[wdg_pkg::CNT_W-1:0];

    assign count_en = ctrl[wdg_pkg::CTRL_CNT_BIT];
    assign trig_en  = ctrl[wdg_pkg::CTRL_TRIG_BIT];

    always_ff @(posedge clk) begin
        if (rst_any) begin
            ctrl <= wdg_pkg::CTRL_RST;
        end else if (hit_ctrl) begin
            ctrl <= ctrl_m[wdg_pkg::CTRL_W-1:0];
        end
    end

    // Edge detect on the oscillator; both edges advance the prescaler
    assign osc_edge = oscillator_input ^ osc_prev;

    always_ff @(posedge clk) begin
        if (rst_any) begin
            osc_prev <= 1'h0;
        end else begin
            osc_prev <= oscillator_input;
        end
    end

    // Compare with >= so a wrap lowered below the count takes effect
    assign tick = osc_edge && (presc >= wrap);

    always_ff @(posedge clk) begin
        if (rst_any) begin
            presc <= wdg_pkg::PRE_ZERO;
        end else if (tick) begin
            presc <= wdg_pkg::PRE_ZERO;
        end else if (osc_edge) begin
            presc <= presc + wdg_pkg::PRE_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst_any) begin
            wrap <= wdg_pkg::WRAP_RST;
        end else if (hit_wrap) begin
            wrap <= wrap_m[wdg_pkg::PRE_W-1:0];
        end
    end

    // Countdown only while enabled and not yet expired
    assign dec  = tick && count_en && (phase == wdg_pkg::WDG_RUN);
    assign fire = dec && !cnt_wr && (count <= wdg_pkg::CNT_ONE);

    always_ff @(posedge clk) begin
        if (rst_any) begin
            phase <= wdg_pkg::WDG_IDLE;
        end else if (!count_en) begin
            phase <= wdg_pkg::WDG_IDLE;
        end else begin
            unique case (phase)
                wdg_pkg::WDG_IDLE: begin
                    phase <= wdg_pkg::WDG_RUN;
                end
                wdg_pkg::WDG_RUN: begin
                    if (fire) begin
                        phase <= wdg_pkg::WDG_EXPIRED;
                    end
                end
                wdg_pkg::WDG_EXPIRED: begin
                    // A fresh nonzero count rearms the timer
                    if (cnt_wr && (cnt_wval != wdg_pkg::CNT_ZERO)) begin
                        phase <= wdg_pkg::WDG_RUN;
                    end
                end
                default: begin
                    phase <= wdg_pkg::WDG_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst_any) begin
            count <= wdg_pkg::CNT_RST;
        end else if (cnt_wr) begin
            count <= cnt_wval;
        end else if (dec && (count != wdg_pkg::CNT_ZERO)) begin
            count <= count - wdg_pkg::CNT_ONE;
        end
    end

    // Held through every reset except power-on, so software can see it
    always_ff @(posedge clk) begin
        if (por) begin
            triggered <= 1'h0;
        end else if (fire && trig_en) begin
            triggered <= 1'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst_any) begin
            chip_reset <= 1'h0;
        end else begin
            chip_reset <= fire && trig_en;
        end
    end

    // Interrupt status: set wins over a same-cycle write-one-clear
    assign irq_evt[wdg_pkg::IRQ_EXPIRE] = fire;
    assign irq_evt[wdg_pkg::IRQ_WRAP]   = tick;
    assign stat_clr = hit_stat ? wdat[wdg_pkg::IRQ_W-1:0] : '0;
    assign irq      = |(irq_stat & irq_mask);

    always_ff @(posedge clk) begin
        if (rst_any) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (irq_stat & ~stat_clr) | irq_evt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst_any) begin
            irq_mask <= '0;
        end else if (hit_mask) begin
            irq_mask <= mask_m[wdg_pkg::IRQ_W-1:0];
        end
    end

    always_comb begin
        rd      = '0;
        rd.ok   = 1'h1;
        unique case (rd_idx)
            wdg_pkg::IDX_CTRL: begin
                rd.data[wdg_pkg::CTRL_W-1:0] = ctrl;
            end
            wdg_pkg::IDX_PRESC: begin
                rd.data[wdg_pkg::PRE_W-1:0] = presc;
            end
            wdg_pkg::IDX_WRAP: begin
                rd.data[wdg_pkg::PRE_W-1:0] = wrap;
            end
            wdg_pkg::IDX_COUNT: begin
                rd.data[wdg_pkg::CNT_W-1:0] = count;
            end
            wdg_pkg::IDX_FLAG: begin
                rd.data[wdg_pkg::FLAG_BIT] = triggered;
            end
            wdg_pkg::IDX_IRQ_STAT: begin
                rd.data[wdg_pkg::IRQ_W-1:0] = irq_stat;
            end
            wdg_pkg::IDX_IRQ_MASK: begin
                rd.data[wdg_pkg::IRQ_W-1:0] = irq_mask;
            end
            default: begin
                rd.ok = 1'h0;
            end
        endcase
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst_any);

    reset_off_a: assert property (
        $fell(rst_any) |-> !count_en && !trig_en && !chip_reset)
        else $error("watchdog active straight after reset");

    count_hold_a: assert property (
        !count_en && !cnt_wr |=> $stable(count))
        else $error("counter moved while disabled");

    no_trig_a: assert property (
        !trig_en |=> !chip_reset)
        else $error("chip reset while reset disabled");

    presc_inc_a: assert property (
        osc_edge && (presc < wrap)
            |=> presc == $past(presc) + wdg_pkg::PRE_ONE)
        else $error("prescaler missed an oscillator edge");

    presc_wrap_a: assert property (
        osc_edge && (presc == wrap)
            |-> tick ##1 presc == wdg_pkg::PRE_ZERO)
        else $error("prescaler did not clear at wrap");

    osc_only_a: assert property (
        !osc_edge |=> $stable(presc))
        else $error("prescaler moved without oscillator edge");

    count_dec_a: assert property (
        dec && !cnt_wr && (count != wdg_pkg::CNT_ZERO)
            |=> count == $past(count) - wdg_pkg::CNT_ONE)
        else $error("counter did not decrement on tick");

    expire_reset_a: assert property (
        fire && trig_en |=> chip_reset && triggered ##1 !chip_reset)
        else $error("expiry did not give one reset pulse");

    flag_keep_a: assert property (
        @(posedge clk) disable iff (por)
        triggered |=> triggered)
        else $error("triggered flag lost without power-on");

    flag_read_a: assert property (
        rd_idx == wdg_pkg::IDX_FLAG
            |-> rd.ok && rd.data[wdg_pkg::FLAG_BIT] == triggered)
        else $error("status read does not show flag");

    count_only_a: assert property (
        fire && !trig_en |=> phase == wdg_pkg::WDG_EXPIRED && !chip_reset)
        else $error("count-only expiry misbehaved");

    hold_zero_a: assert property (
        count_en && !trig_en && (phase == wdg_pkg::WDG_EXPIRED)
            && !cnt_wr |=> count == wdg_pkg::CNT_ZERO
            && $stable(triggered))
        else $error("expired counter did not hold at zero");

    write_load_a: assert property (
        cnt_wr |=> count == $past(cnt_wval))
        else $error("counter write not applied");

    irq_sticky_a: assert property (
        fire |=> irq_stat[wdg_pkg::IRQ_EXPIRE]
            ##1 (irq_stat[wdg_pkg::IRQ_EXPIRE]
                 || $past(stat_clr[wdg_pkg::IRQ_EXPIRE])))
        else $error("expiry status not sticky");

    cov_reset_c: cover property (fire && trig_en ##1 chip_reset);
    cov_debug_c: cover property (fire && !trig_en);
    cov_rearm_c: cover property (
        cnt_wr && (phase == wdg_pkg::WDG_EXPIRED));
    cov_tick_c: cover property (dec ##[1:20] dec);
endmodule

/* rtl/wdg_pkg.sv */
// Constants, types and carriers for the oscillator watchdog timer
package wdg_pkg;
    localparam int ADDR_W  = 18;
    localparam int IDX_W   = 16;
    localparam int IDX_LSB = 2;
    localparam int DATA_W  = 32;
    localparam int STRB_W  = 4;
    localparam int BYTE_W  = 8;
    localparam int PRE_W   = 16;
    localparam int CNT_W   = 12;
    localparam int CTRL_W  = 2;
    localparam int IRQ_W   = 2;

    // Register indices; the byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CTRL     = 16'hF020;
    localparam logic [IDX_W-1:0] IDX_PRESC    = 16'hF021;
    localparam logic [IDX_W-1:0] IDX_WRAP     = 16'hF022;
    localparam logic [IDX_W-1:0] IDX_COUNT    = 16'hF023;
    localparam logic [IDX_W-1:0] IDX_FLAG     = 16'hF024;
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 16'hF025;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 16'hF026;

    localparam int CTRL_CNT_BIT  = 0;
    localparam int CTRL_TRIG_BIT = 1;
    localparam int FLAG_BIT      = 0;
    localparam int IRQ_EXPIRE    = 0;
    localparam int IRQ_WRAP      = 1;

    localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;
    localparam logic [CNT_W-1:0]  CNT_RST  = 12'hFFF;
    localparam logic [CNT_W-1:0]  CNT_ONE  = 12'h001;
    localparam logic [CNT_W-1:0]  CNT_ZERO = 12'h000;
    localparam logic [PRE_W-1:0]  WRAP_RST = 16'hFFFF;
    localparam logic [PRE_W-1:0]  PRE_ONE  = 16'h0001;
    localparam logic [PRE_W-1:0]  PRE_ZERO = 16'h0000;
    localparam logic [1:0]        RESP_OKAY   = 2'h0;
    localparam logic [1:0]        RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        WDG_IDLE    = 3'h1,
        WDG_RUN     = 3'h2,
        WDG_EXPIRED = 3'h4
    } wdg_phase_e;

    typedef struct packed {
        logic [IDX_W-1:0]  idx;
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] mask;
    } wdg_wr_s;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic              ok;
    } wdg_rd_s;
endpackage

/* rtl/wdg_axil_slave.sv */
// AXI4-Lite slave front end of the watchdog register file
`timescale 1ns/1ps
module wdg_axil_slave (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic [wdg_pkg::ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [wdg_pkg::DATA_W-1:0]    s_axi_wdata,
    input  wire logic [wdg_pkg::STRB_W-1:0]    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [wdg_pkg::ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [wdg_pkg::DATA_W-1:0]         s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    output wdg_pkg::wdg_wr_s                   wr,
    output logic                               wr_valid,
    input  wire logic                          wr_ok,
    output logic [wdg_pkg::IDX_W-1:0]          rd_idx,
    input  wdg_pkg::wdg_rd_s                   rd
);
    logic                         aw_held;
    logic                         w_held;
    logic [wdg_pkg::IDX_W-1:0]    aw_idx;
    logic [wdg_pkg::DATA_W-1:0]   w_data;
    logic [wdg_pkg::STRB_W-1:0]   w_strb;
    logic [wdg_pkg::DATA_W-1:0]   w_mask;

    // Address and data may arrive in either order; both wait here
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_valid      = aw_held && w_held;
    assign rd_idx = s_axi_araddr[wdg_pkg::ADDR_W-1:wdg_pkg::IDX_LSB];
    assign wr.idx  = aw_idx;
    assign wr.data = w_data;
    assign wr.mask = w_mask;

    genvar b;
    generate
        for (b = 0; b < wdg_pkg::STRB_W; b++) begin : g_lane
            assign w_mask[b*wdg_pkg::BYTE_W +: wdg_pkg::BYTE_W] =
                {wdg_pkg::BYTE_W{w_strb[b]}};
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_held <= 1'h0;
            aw_idx  <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'h1;
            aw_idx  <= s_axi_awaddr[wdg_pkg::ADDR_W-1:wdg_pkg::IDX_LSB];
        end else if (wr_valid) begin
            aw_held <= 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            w_held <= 1'h0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'h1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_valid) begin
            w_held <= 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'h0;
            s_axi_bresp  <= wdg_pkg::RESP_OKAY;
        end else if (wr_valid) begin
            s_axi_bvalid <= 1'h1;
            s_axi_bresp  <= wr_ok ? wdg_pkg::RESP_OKAY
                                  : wdg_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'h0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= wdg_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'h1;
            s_axi_rdata  <= rd.data;
            s_axi_rresp  <= rd.ok ? wdg_pkg::RESP_OKAY
                                  : wdg_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'h0;
        end
    end
endmodule

/* bench/test_oscillator_watchdog_timer.sv */
// Self-checking register-level testbench for the watchdog timer
`timescale 1ns/1ps
module test_oscillator_watchdog_timer;
    logic                       clk = 1'b0;
    logic                       rst = 1'b1;
    logic                       por = 1'b1;
    logic                       osc = 1'b0;
    logic [wdg_pkg::ADDR_W-1:0] awaddr = '0;
    logic                       awvalid = 1'b0;
    logic                       awready;
    logic [31:0]                wdata = '0;
    logic [3:0]                 wstrb = 4'h0;
    logic                       wvalid = 1'b0;
    logic                       wready;
    logic [1:0]                 bresp;
    logic                       bvalid;
    logic                       bready = 1'b0;
    logic [wdg_pkg::ADDR_W-1:0] araddr = '0;
    logic                       arvalid = 1'b0;
    logic                       arready;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
    logic                       rvalid;
    logic                       rready = 1'b0;
    logic                       chip_reset;
    logic                       irq;
    logic [1:0]                 resp;
    logic [31:0]                data;
    int                         num_errors = 0;
    int                         compares = 0;
    int                         pulses = 0;

    always #5 clk = ~clk;

    wdg_timer wdg_timer_inst (.clk(clk), .rst(rst), .por(por),
        .oscillator_input(osc), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .chip_reset(chip_reset), .irq(irq));

    // Pulses are counted so a missed or doubled reset request shows
    always @(posedge clk) begin
        if (chip_reset === 1'b1)
            pulses <= pulses + 1;
    end

    task automatic finish_test;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string msg);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got,
                     exp);
        end
    endtask

    function automatic logic [wdg_pkg::ADDR_W-1:0] adr(
        input logic [wdg_pkg::IDX_W-1:0] idx);
        return {idx, 2'h0};
    endfunction

    // Handshakes sampled at the falling edge: values are stable then
    task automatic axi_write(input logic [wdg_pkg::IDX_W-1:0] idx,
                             input logic [31:0] d);
        logic aw_hit;
        logic w_hit;
        logic b_hit;
        int   n;
        b_hit = 1'b0;
        n = 0;
        @(posedge clk);
        awaddr <= adr(idx);
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_hit && n < 200) begin
            @(negedge clk);
            aw_hit = awvalid && (awready === 1'b1);
            w_hit = wvalid && (wready === 1'b1);
            b_hit = (bvalid === 1'b1);
            if (b_hit)
                resp = bresp;
            @(posedge clk);
            if (aw_hit)
                awvalid <= 1'b0;
            if (w_hit)
                wvalid <= 1'b0;
            if (b_hit)
                bready <= 1'b0;
            n++;
        end
        if (!b_hit)
            check(32'h0, 32'h1, "write response missing");
    endtask

    task automatic axi_read(input logic [wdg_pkg::IDX_W-1:0] idx);
        logic ar_hit;
        logic r_hit;
        int   n;
        r_hit = 1'b0;
        n = 0;
        @(posedge clk);
        araddr <= adr(idx);
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_hit && n < 200) begin
            @(negedge clk);
            ar_hit = arvalid && (arready === 1'b1);
            r_hit = (rvalid === 1'b1);
            if (r_hit) begin
                data = rdata;
                resp = rresp;
            end
            @(posedge clk);
            if (ar_hit)
                arvalid <= 1'b0;
            if (r_hit)
                rready <= 1'b0;
            n++;
        end
        if (!r_hit)
            check(32'h0, 32'h1, "read response missing");
    endtask

    task automatic rd(input logic [wdg_pkg::IDX_W-1:0] idx,
                      input logic [31:0] exp, input string msg);
        axi_read(idx);
        check(data, exp, msg);
    endtask

    // Each level held three clocks, longer than the one clock minimum
    task automatic osc_edges(input int n);
        repeat (n) begin
            @(posedge clk);
            osc <= ~osc;
            repeat (2) @(posedge clk);
        end
        repeat (3) @(posedge clk);
    endtask

    task automatic pulse_reset(input logic power);
        @(posedge clk);
        if (power)
            por <= 1'b1;
        else
            rst <= 1'b1;
        repeat (2) @(posedge clk);
        por <= 1'b0;
        rst <= 1'b0;
    endtask

    initial begin
        #200000;
        num_errors++;
        finish_test();
    end

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        por <= 1'b0;
        rd(wdg_pkg::IDX_CTRL, 32'h0, "ctrl reset");
        rd(wdg_pkg::IDX_PRESC, 32'h0, "prescaler reset");
        rd(wdg_pkg::IDX_WRAP, 32'h0000FFFF, "wrap reset");
        rd(wdg_pkg::IDX_COUNT, 32'h00000FFF, "counter reset");
        rd(wdg_pkg::IDX_FLAG, 32'h0, "flag after power-on");
        rd(16'h0100, 32'h0, "unmapped read data");
        check(resp, 32'h2, "unmapped read resp");
        axi_write(wdg_pkg::IDX_PRESC, 32'h0000ABCD);
        check(resp, 32'h0, "read-only write resp");
        axi_write(16'h0100, 32'h0);
        check(resp, 32'h2, "unmapped write resp");
        axi_write(wdg_pkg::IDX_WRAP, 32'h00000003);
        osc_edges(6);
        rd(wdg_pkg::IDX_PRESC, 32'h2, "prescaler wraps at 3");
        rd(wdg_pkg::IDX_COUNT, 32'h00000FFF, "counter holds");
        osc_edges(2);
        axi_write(wdg_pkg::IDX_CTRL, 32'h1);
        axi_write(wdg_pkg::IDX_COUNT, 32'h00000005);
        rd(wdg_pkg::IDX_COUNT, 32'h5, "counter write");
        osc_edges(4);
        rd(wdg_pkg::IDX_COUNT, 32'h4, "one tick per 4 edges");
        axi_write(wdg_pkg::IDX_COUNT, 32'h00000002);
        osc_edges(12);
        rd(wdg_pkg::IDX_COUNT, 32'h0, "count-only holds zero");
        rd(wdg_pkg::IDX_FLAG, 32'h0, "count-only flag");
        check(pulses, 0, "count-only no chip reset");
        check(irq, 1'b0, "irq masked");
        axi_write(wdg_pkg::IDX_IRQ_MASK, 32'h1);
        check(irq, 1'b1, "irq on expiry");
        rd(wdg_pkg::IDX_IRQ_STAT, 32'h3, "irq status both events");
        axi_write(wdg_pkg::IDX_IRQ_STAT, 32'h3);
        repeat (2) @(posedge clk);
        check(irq, 1'b0, "irq cleared");
        rd(wdg_pkg::IDX_IRQ_STAT, 32'h0, "irq status cleared");
        axi_write(wdg_pkg::IDX_CTRL, 32'h3);
        axi_write(wdg_pkg::IDX_COUNT, 32'h00000001);
        osc_edges(4);
        check(pulses, 1, "chip reset on expiry");
        rd(wdg_pkg::IDX_FLAG, 32'h1, "flag set");
        check(irq, 1'b1, "irq after trigger");
        pulse_reset(1'b0);
        rd(wdg_pkg::IDX_FLAG, 32'h1, "flag survives reset");
        rd(wdg_pkg::IDX_CTRL, 32'h0, "ctrl after reset");
        check(irq, 1'b0, "irq after reset");
        pulse_reset(1'b1);
        rd(wdg_pkg::IDX_FLAG, 32'h0, "flag cleared by power-on");
        finish_test();
    end
endmodule
